// [design/ebapt_defs.svh]
// constants for the external bus access phase timer
`ifndef EBAPT_DEFS_SVH
`define EBAPT_DEFS_SVH

// zone and field widths
`define EBAPT_ZONES      8
`define EBAPT_ZONE_W     3
`define EBAPT_LEAD_W     2
`define EBAPT_ACT_W      3
`define EBAPT_TRAIL_W    2
`define EBAPT_ADDR_W     19
`define EBAPT_CNT_W      5
`define EBAPT_DIV_W      3

// counter values
`define EBAPT_CNT_ZERO   5'h00
`define EBAPT_CNT_ONE    5'h01
`define EBAPT_DIV_ZERO   3'h0
`define EBAPT_DIV_ONE    3'h1

// mclk masks: timing tick and bus clock periods of 2, 4 or 8 mclk cycles
`define EBAPT_MASK_P2    3'h1
`define EBAPT_MASK_P4    3'h3
`define EBAPT_MASK_P8    3'h7

`endif

// [design/ebapt_pkg.sv]
// types for the external bus access phase timer
package ebapt_pkg;

	// clock ratio modes: timing clock / bus clock relative to system_clock
	typedef enum logic [1:0] {
		EBAPT_MODE_EQ      = 2'b00,   // both at system_clock
		EBAPT_MODE_HALFOUT = 2'b01,   // timing full, bus clock half
		EBAPT_MODE_HALFALL = 2'b10,   // both at half
		EBAPT_MODE_QUARTER = 2'b11    // timing half, bus clock quarter
	} ebapt_clk_mode_t;

	// access phase sequencer states
	typedef enum logic [1:0] {
		EBAPT_ST_IDLE   = 2'b00,
		EBAPT_ST_LEAD   = 2'b01,
		EBAPT_ST_ACTIVE = 2'b10,
		EBAPT_ST_TRAIL  = 2'b11
	} ebapt_state_t;

endpackage : ebapt_pkg

// [design/ebapt_top.sv]
// external bus access phase timer: request crossing, clock ratios, phase sequencer
`timescale 1ns/1ps
`include "ebapt_defs.svh"

module ebapt_top (
	input  wire logic                                   mclk,                 // system clock, 2x system_clock
	input  wire logic                                   resetn,               // async reset, active low
	input  wire logic                                   clk_en,               // freezes access side mclk state when low
	input  wire logic                                   cpu_clk,              // request side clock
	input  wire logic                                   req_valid,            // access request
	output logic                                        req_ready,            // request may be taken
	input  wire logic                                   req_write,            // 1 write, 0 read
	input  wire logic [`EBAPT_ZONE_W-1:0]               req_zone,             // zone of request
	input  wire logic [`EBAPT_ADDR_W-1:0]               req_addr,             // address of request
	input  wire ebapt_pkg::ebapt_clk_mode_t             clk_mode,             // clock ratio mode
	input  wire logic [`EBAPT_ZONES*`EBAPT_LEAD_W-1:0]  read_lead_count,      // per zone
	input  wire logic [`EBAPT_ZONES*`EBAPT_ACT_W-1:0]   read_active_count,    // per zone
	input  wire logic [`EBAPT_ZONES*`EBAPT_TRAIL_W-1:0] read_trail_count,     // per zone
	input  wire logic [`EBAPT_ZONES*`EBAPT_LEAD_W-1:0]  write_lead_count,     // per zone
	input  wire logic [`EBAPT_ZONES*`EBAPT_ACT_W-1:0]   write_active_count,   // per zone
	input  wire logic [`EBAPT_ZONES*`EBAPT_TRAIL_W-1:0] write_trail_count,    // per zone
	input  wire logic [`EBAPT_ZONES-1:0]                double_phase_multiplier, // per zone
	input  wire logic [`EBAPT_ZONES-1:0]                ready_sampling_enable,   // per zone
	input  wire logic [`EBAPT_ZONES-1:0]                ready_async_select,      // per zone
	input  wire logic                                   ext_ready_in,         // external ready pin
	output logic                                        bus_clock_out,        // external bus clock
	output logic                                        phase_timing_clock,   // timing clock tick, one mclk
	output logic                                        read_strobe_n,        // read strobe
	output logic                                        write_strobe_n,       // write strobe
	output logic [`EBAPT_ZONES-1:0]                     zone_select_n,        // zone selects
	output logic                                        bus_direction,        // 1 read, 0 write
	output logic [`EBAPT_ADDR_W-1:0]                    ext_address_bus,      // address bus
	output logic                                        access_busy           // access in progress
);
	import ebapt_pkg::*;

	// ==========================================================
	// functions
	function automatic logic [`EBAPT_CNT_W-1:0] phase_len(input logic [`EBAPT_ACT_W-1:0] cnt, input logic dbl);
		logic [`EBAPT_CNT_W-1:0] v;
		v = {{(`EBAPT_CNT_W-`EBAPT_ACT_W){1'b0}}, cnt};
		phase_len = dbl ? (v << 1) : v;
	endfunction : phase_len

	function automatic logic [`EBAPT_DIV_W-1:0] tim_mask(input ebapt_clk_mode_t m);
		tim_mask = (m == EBAPT_MODE_EQ || m == EBAPT_MODE_HALFOUT) ? `EBAPT_MASK_P2 : `EBAPT_MASK_P4;
	endfunction : tim_mask

	function automatic logic [`EBAPT_DIV_W-1:0] out_mask(input ebapt_clk_mode_t m);
		unique case (m)
			EBAPT_MODE_EQ:      out_mask = `EBAPT_MASK_P2;
			EBAPT_MODE_HALFOUT: out_mask = `EBAPT_MASK_P4;
			EBAPT_MODE_HALFALL: out_mask = `EBAPT_MASK_P4;
			EBAPT_MODE_QUARTER: out_mask = `EBAPT_MASK_P8;
		endcase
	endfunction : out_mask

	// ==========================================================
	// reset release, one synchroniser per domain
	logic m_rst_s1_q, m_rst_s2_q, c_rst_s1_q, c_rst_s2_q;

	// mclk reset release
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			m_rst_s1_q <= 1'b0;
			m_rst_s2_q <= 1'b0;
		end else begin
			m_rst_s1_q <= 1'b1;
			m_rst_s2_q <= m_rst_s1_q;
		end
	end

	// cpu_clk reset release
	always_ff @(posedge cpu_clk or negedge resetn) begin
		if (!resetn) begin
			c_rst_s1_q <= 1'b0;
			c_rst_s2_q <= 1'b0;
		end else begin
			c_rst_s1_q <= 1'b1;
			c_rst_s2_q <= c_rst_s1_q;
		end
	end

	// ==========================================================
	// request side (cpu_clk): hold request, toggle handshake
	logic                     busy_q, busy_d, req_tgl_q, req_tgl_d;
	logic                     done_s1_q, done_s2_q, done_seen_q, done_seen_d;
	logic                     hold_wr_q, hold_wr_d;
	logic [`EBAPT_ZONE_W-1:0] hold_zone_q, hold_zone_d;
	logic [`EBAPT_ADDR_W-1:0] hold_addr_q, hold_addr_d;
	logic                     done_tgl_q;

	assign req_ready = !busy_q;

	// take a request, free again once the done toggle returns
	always_comb begin
		busy_d      = busy_q;
		req_tgl_d   = req_tgl_q;
		done_seen_d = done_seen_q;
		hold_wr_d   = hold_wr_q;
		hold_zone_d = hold_zone_q;
		hold_addr_d = hold_addr_q;
		if (busy_q && (done_s2_q != done_seen_q)) begin
			busy_d      = 1'b0;
			done_seen_d = done_s2_q;
		end else if (!busy_q && req_valid) begin
			busy_d      = 1'b1;
			req_tgl_d   = !req_tgl_q;
			hold_wr_d   = req_write;
			hold_zone_d = req_zone;
			hold_addr_d = req_addr;
		end
	end

	// request side registers
	always_ff @(posedge cpu_clk or negedge c_rst_s2_q) begin
		if (!c_rst_s2_q) begin
			busy_q      <= 1'b0;
			req_tgl_q   <= 1'b0;
			done_s1_q   <= 1'b0;
			done_s2_q   <= 1'b0;
			done_seen_q <= 1'b0;
			hold_wr_q   <= 1'b0;
			hold_zone_q <= '0;
			hold_addr_q <= '0;
		end else begin
			busy_q      <= busy_d;
			req_tgl_q   <= req_tgl_d;
			done_s1_q   <= done_tgl_q;
			done_s2_q   <= done_s1_q;
			done_seen_q <= done_seen_d;
			hold_wr_q   <= hold_wr_d;
			hold_zone_q <= hold_zone_d;
			hold_addr_q <= hold_addr_d;
		end
	end

	// ==========================================================
	// access side (mclk): dividers, ready sampling, phase sequencer
	ebapt_state_t             st_q, st_d;
	logic [`EBAPT_DIV_W-1:0]  div_q, div_d;
	logic [`EBAPT_CNT_W-1:0]  cnt_q, cnt_d;
	logic                     req_s1_q, req_s2_q, req_seen_q, req_seen_d;
	logic                     rdy_s1_q, rdy_s2_q, rdy_s3_q;
	logic                     wr_q, wr_d, done_tgl_d;
	logic [`EBAPT_ZONE_W-1:0] zone_q, zone_d;
	logic [`EBAPT_ADDR_W-1:0] addr_q, addr_d;
	logic                     bclk_q, bclk_d, tick_q, tick_d;
	logic                     tick, out_rise, rdy;
	logic [`EBAPT_ACT_W-1:0]  lead_c, act_c, trail_c;
	logic [`EBAPT_CNT_W-1:0]  lead_len, act_len, trail_len;
	logic                     dbl, use_rdy;

	// timing tick and bus clock edges at the new divider value
	assign div_d    = div_q + `EBAPT_DIV_ONE;
	assign tick     = clk_en && ((div_d & tim_mask(clk_mode)) == `EBAPT_DIV_ZERO);
	assign out_rise = (div_d & out_mask(clk_mode)) == `EBAPT_DIV_ZERO;
	assign bclk_d   = (div_d & out_mask(clk_mode) & ~(out_mask(clk_mode) >> 1)) == `EBAPT_DIV_ZERO;
	assign tick_d   = tick;

	// zone settings of the access in flight
	always_comb begin
		dbl     = double_phase_multiplier[zone_q];
		use_rdy = ready_sampling_enable[zone_q];
		lead_c  = {1'b0, wr_q ? write_lead_count[zone_q*`EBAPT_LEAD_W +: `EBAPT_LEAD_W]
		                      : read_lead_count[zone_q*`EBAPT_LEAD_W +: `EBAPT_LEAD_W]};
		act_c   = wr_q ? write_active_count[zone_q*`EBAPT_ACT_W +: `EBAPT_ACT_W]
		               : read_active_count[zone_q*`EBAPT_ACT_W +: `EBAPT_ACT_W];
		trail_c = {1'b0, wr_q ? write_trail_count[zone_q*`EBAPT_TRAIL_W +: `EBAPT_TRAIL_W]
		                      : read_trail_count[zone_q*`EBAPT_TRAIL_W +: `EBAPT_TRAIL_W]};
	end

	// phase lengths; active carries its extra cycle, no legality check
	assign lead_len  = phase_len(lead_c, dbl);
	assign act_len   = phase_len(act_c, dbl) + `EBAPT_CNT_ONE;
	assign trail_len = phase_len(trail_c, dbl);
	// asynchronous mode takes one extra stage
	assign rdy       = ready_async_select[zone_q] ? rdy_s3_q : rdy_s2_q;

	// sequencer: waits for a rising bus clock edge, then lead, active, trail
	always_comb begin
		st_d       = st_q;
		cnt_d      = cnt_q;
		req_seen_d = req_seen_q;
		wr_d       = wr_q;
		zone_d     = zone_q;
		addr_d     = addr_q;
		done_tgl_d = done_tgl_q;
		if (tick) begin
			unique case (st_q)
				EBAPT_ST_IDLE: begin
					if ((req_s2_q != req_seen_q) && out_rise) begin
						req_seen_d = req_s2_q;
						wr_d       = hold_wr_q;
						zone_d     = hold_zone_q;
						addr_d     = hold_addr_q;
						st_d       = EBAPT_ST_LEAD;
						cnt_d      = `EBAPT_CNT_ZERO;
					end
				end
				EBAPT_ST_LEAD: begin
					if (cnt_q + `EBAPT_CNT_ONE >= lead_len) begin
						st_d  = EBAPT_ST_ACTIVE;
						cnt_d = `EBAPT_CNT_ZERO;
					end else begin
						cnt_d = cnt_q + `EBAPT_CNT_ONE;
					end
				end
				EBAPT_ST_ACTIVE: begin
					if (cnt_q + `EBAPT_CNT_ONE < act_len) begin
						cnt_d = cnt_q + `EBAPT_CNT_ONE;
					end else if (use_rdy && !rdy) begin
						cnt_d = cnt_q;
					end else if (trail_len == `EBAPT_CNT_ZERO) begin
						st_d       = EBAPT_ST_IDLE;
						done_tgl_d = !done_tgl_q;
					end else begin
						st_d  = EBAPT_ST_TRAIL;
						cnt_d = `EBAPT_CNT_ZERO;
					end
				end
				EBAPT_ST_TRAIL: begin
					if (cnt_q + `EBAPT_CNT_ONE >= trail_len) begin
						st_d       = EBAPT_ST_IDLE;
						done_tgl_d = !done_tgl_q;
					end else begin
						cnt_d = cnt_q + `EBAPT_CNT_ONE;
					end
				end
			endcase
		end
	end

	// access side registers, frozen while clk_en is low
	always_ff @(posedge mclk or negedge m_rst_s2_q) begin
		if (!m_rst_s2_q) begin
			st_q       <= EBAPT_ST_IDLE;
			div_q      <= `EBAPT_DIV_ZERO;
			cnt_q      <= `EBAPT_CNT_ZERO;
			req_s1_q   <= 1'b0;
			req_s2_q   <= 1'b0;
			req_seen_q <= 1'b0;
			rdy_s1_q   <= 1'b0;
			rdy_s2_q   <= 1'b0;
			rdy_s3_q   <= 1'b0;
			wr_q       <= 1'b0;
			zone_q     <= '0;
			addr_q     <= '0;
			done_tgl_q <= 1'b0;
			bclk_q     <= 1'b0;
			tick_q     <= 1'b0;
		end else if (clk_en) begin
			st_q       <= st_d;
			div_q      <= div_d;
			cnt_q      <= cnt_d;
			req_s1_q   <= req_tgl_q;
			req_s2_q   <= req_s1_q;
			req_seen_q <= req_seen_d;
			rdy_s1_q   <= ext_ready_in;
			rdy_s2_q   <= rdy_s1_q;
			rdy_s3_q   <= rdy_s2_q;
			wr_q       <= wr_d;
			zone_q     <= zone_d;
			addr_q     <= addr_d;
			done_tgl_q <= done_tgl_d;
			bclk_q     <= bclk_d;
			tick_q     <= tick_d;
		end
	end

	// ==========================================================
	// strobes follow the state register, so they change with ticks only
	assign phase_timing_clock = tick_q;
	assign bus_clock_out      = bclk_q;
	assign ext_address_bus    = addr_q;
	assign access_busy        = st_q != EBAPT_ST_IDLE;

	// idle and alignment cycles show all strobes inactive
	always_comb begin
		zone_select_n  = '1;
		read_strobe_n  = 1'b1;
		write_strobe_n = 1'b1;
		bus_direction  = 1'b1;
		if (st_q != EBAPT_ST_IDLE) begin
			zone_select_n[zone_q] = 1'b0;
			bus_direction         = !wr_q;
		end
		if (st_q == EBAPT_ST_ACTIVE) begin
			read_strobe_n  = wr_q;
			write_strobe_n = !wr_q;
		end
	end

endmodule : ebapt_top

// [verif/ebapt_top_props.sv]
// checker of the access phase timer ports
`timescale 1ns/1ps
`include "ebapt_defs.svh"
module ebapt_top_props (
	input wire logic                          mclk,               // system clock
	input wire logic                          resetn,             // reset, active low
	input wire ebapt_pkg::ebapt_clk_mode_t    clk_mode,           // clock ratio mode
	input wire logic                          bus_clock_out,      // bus clock
	input wire logic                          phase_timing_clock, // timing tick
	input wire logic                          read_strobe_n,      // read strobe
	input wire logic                          write_strobe_n,     // write strobe
	input wire logic [`EBAPT_ZONES-1:0]       zone_select_n,      // zone selects
	input wire logic                          bus_direction,      // 1 read
	input wire logic [`EBAPT_ADDR_W-1:0]      ext_address_bus,    // address
	input wire logic                          access_busy         // busy
);
	import ebapt_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ==========================================
	// strobe alignment
	a_start_on_rise: assert property ($fell(&zone_select_n) |-> $rose(bus_clock_out))
		else $error("access start off a rising bus clock edge");
	a_eq_rate_rise: assert property ((clk_mode == EBAPT_MODE_EQ || clk_mode == EBAPT_MODE_HALFALL) &&
		$changed({read_strobe_n, write_strobe_n, zone_select_n, bus_direction}) |-> $rose(bus_clock_out))
		else $error("strobe change off a rising bus clock edge");
	a_half_any_edge: assert property ((clk_mode == EBAPT_MODE_HALFOUT || clk_mode == EBAPT_MODE_QUARTER) &&
		$changed({read_strobe_n, write_strobe_n, zone_select_n, bus_direction}) |-> $changed(bus_clock_out))
		else $error("strobe change off a bus clock edge");
	a_change_on_tick: assert property ($changed({read_strobe_n, write_strobe_n, zone_select_n}) |->
		phase_timing_clock)
		else $error("strobe change without timing tick");
	// ==========================================
	// strobe consistency
	a_one_zone: assert property ($onehot0(~zone_select_n))
		else $error("more than one zone selected");
	a_strobe_in_sel: assert property (!(read_strobe_n && write_strobe_n) |-> !(&zone_select_n) &&
		(read_strobe_n || write_strobe_n))
		else $error("strobe outside select");
	a_dir_matches: assert property ((!write_strobe_n |-> !bus_direction) and
		(!read_strobe_n |-> bus_direction))
		else $error("direction disagrees with strobe");
	a_idle_inactive: assert property (!access_busy |-> &zone_select_n && bus_direction &&
		read_strobe_n && write_strobe_n)
		else $error("strobe active while idle");
	a_addr_hold: assert property (&zone_select_n && $past(&zone_select_n) |-> $stable(ext_address_bus))
		else $error("address moved while idle");
endmodule : ebapt_top_props
bind ebapt_top ebapt_top_props u_props (.mclk(mclk), .resetn(resetn), .clk_mode(clk_mode),
	.bus_clock_out(bus_clock_out), .phase_timing_clock(phase_timing_clock), .read_strobe_n(read_strobe_n),
	.write_strobe_n(write_strobe_n), .zone_select_n(zone_select_n), .bus_direction(bus_direction),
	.ext_address_bus(ext_address_bus), .access_busy(access_busy));

// [verif/ebapt_bus_dev.sv]
// model of a slow bus device driving the ready pin
`timescale 1ns/1ps
module ebapt_bus_dev (
	input  wire logic mclk,          // system clock
	input  wire logic resetn,        // reset, active low
	input  wire logic read_strobe_n, // read strobe
	input  wire logic write_strobe_n,// write strobe
	input  wire integer hold_cycles, // strobe fall to ready rise, in mclk cycles
	output logic      ext_ready_in   // ready pin, pulled up when idle
);
	int cnt;
	// ready held low from the mclk after a strobe falls until hold_cycles mclk after the fall
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 0;
			ext_ready_in <= 1'b1;
		end else if (read_strobe_n && write_strobe_n) begin
			cnt <= 0;
			ext_ready_in <= 1'b1;
		end else begin
			cnt <= cnt + 1;
			ext_ready_in <= (cnt + 1 >= hold_cycles);
		end
	end
endmodule : ebapt_bus_dev

// [verif/tb_ext_bus_access_phase_timer.sv]
// testbench of the access phase timer
`timescale 1ns/1ps
`include "ebapt_defs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
	$display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb_ext_bus_access_phase_timer;
	import ebapt_pkg::*;
	logic mclk, resetn, cpu_clk, req_valid, req_write, ext_ready_in, clk_en;
	logic [1:0] frz;
	logic [2:0] req_zone;
	logic [18:0] req_addr;
	ebapt_clk_mode_t clk_mode;
	logic [15:0] rl, wl, rt, wt;
	logic [23:0] ra, wa;
	logic [7:0] x2, use_rdy, asy;
	logic req_ready, bus_clock_out, ptc, rd_n, wr_n, dir, busy;
	logic [7:0] sel_n;
	logic [18:0] addr;
	int bad_count, compares, cyc, sel_cyc, stb_cyc, hold;
	logic stb_q, bclk_q, rise_at_stb;
	// case table: mode, write, lead, active, trail, double, ready use, async, hold
	int md[7] = '{0, 1, 2, 3, 0, 1, 2};
	int wrt[7] = '{0, 1, 0, 1, 0, 0, 1};
	int ld[7] = '{1, 1, 3, 1, 1, 2, 1};
	int ac[7] = '{0, 1, 7, 2, 1, 1, 2};
	int tr[7] = '{0, 1, 3, 0, 0, 0, 1};
	int dbl[7] = '{0, 1, 0, 0, 1, 0, 0};
	int ur[7] = '{0, 0, 1, 1, 1, 1, 0};
	int as[7] = '{0, 0, 0, 1, 1, 0, 0};
	int hc[7] = '{0, 0, 0, 0, 0, 12, 12};
	ebapt_top dut (.mclk(mclk), .resetn(resetn), .clk_en(clk_en), .cpu_clk(cpu_clk), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_zone(req_zone), .req_addr(req_addr),
		.clk_mode(clk_mode), .read_lead_count(rl), .read_active_count(ra), .read_trail_count(rt),
		.write_lead_count(wl), .write_active_count(wa), .write_trail_count(wt),
		.double_phase_multiplier(x2), .ready_sampling_enable(use_rdy), .ready_async_select(asy),
		.ext_ready_in(ext_ready_in), .bus_clock_out(bus_clock_out), .phase_timing_clock(ptc),
		.read_strobe_n(rd_n), .write_strobe_n(wr_n), .zone_select_n(sel_n), .bus_direction(dir),
		.ext_address_bus(addr), .access_busy(busy));
	ebapt_bus_dev u_dev (.mclk(mclk), .resetn(resetn), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
		.hold_cycles(hold), .ext_ready_in(ext_ready_in));
	// ==========================================
	// clocks, monitor and hang guard
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		cpu_clk = 1'b0;
		#7;
		forever #32 cpu_clk = ~cpu_clk;
	end
	always @(posedge mclk) begin
		#1;
		if (!(&sel_n)) sel_cyc++;
		if (!(rd_n && wr_n)) stb_cyc++;
		if (!(rd_n && wr_n) && !stb_q) rise_at_stb = bus_clock_out && !bclk_q;
		stb_q = !(rd_n && wr_n);
		bclk_q = bus_clock_out;
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			close_out();
		end
	end
	task automatic close_out();
		if (bad_count == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out
	// one access through the request handshake, then its phase lengths
	task automatic access(input int i);
		int m, p, l, a, base, n;
		m = dbl[i] ? 2 : 1;
		p = (md[i] < 2) ? 2 : 4;
		l = (ld[i] * m == 0) ? 1 : ld[i] * m;
		a = ac[i] * m + 1;
		@(posedge mclk);
		clk_mode <= ebapt_clk_mode_t'(md[i]);
		hold <= hc[i];
		repeat (24) @(posedge mclk);
		sel_cyc = 0;
		stb_cyc = 0;
		@(posedge cpu_clk);
		req_valid <= 1'b1;
		req_write <= wrt[i][0];
		req_zone <= i[2:0];
		req_addr <= 19'h0a5c3 + 19'(i);
		do @(posedge cpu_clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		n = 0;
		while (n < 400 && !(sel_cyc > 0 && busy === 1'b0 && &sel_n)) begin
			@(posedge mclk);
			n++;
		end
		base = a * p;
		`CHK("access ended", 1, int'(n < 400))
		if (hc[i] != 0 && ur[i] != 0) begin
			`CHK("stretched active", 1, int'(stb_cyc > base))
			`CHK("lead and trail", (l + tr[i] * m) * p, sel_cyc - stb_cyc)
		end else begin
			`CHK("active cycles", base, stb_cyc)
			`CHK("access cycles", (l + a + tr[i] * m) * p, sel_cyc)
		end
		if (md[i] == 1 || md[i] == 3) `CHK("strobe edge", (l % 2 == 0), rise_at_stb)
		`CHK("held address", 19'h0a5c3 + 19'(i), addr)
	endtask : access
	// ==========================================
	// main sequence
	initial begin
		bad_count = 0;
		compares = 0;
		cyc = 0;
		hold = 0;
		stb_q = 1'b0;
		bclk_q = 1'b0;
		rise_at_stb = 1'b0;
		resetn = 1'b0;
		clk_en = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_zone = 3'h0;
		req_addr = 19'h00000;
		clk_mode = EBAPT_MODE_EQ;
		{rl, wl, rt, wt, ra, wa, x2, use_rdy, asy} = '0;
		for (int z = 0; z < 7; z++) begin
			rl[z*2 +: 2] = ld[z][1:0];
			wl[z*2 +: 2] = ld[z][1:0];
			ra[z*3 +: 3] = ac[z][2:0];
			wa[z*3 +: 3] = ac[z][2:0];
			rt[z*2 +: 2] = tr[z][1:0];
			wt[z*2 +: 2] = tr[z][1:0];
			x2[z] = dbl[z][0];
			use_rdy[z] = ur[z][0];
			asy[z] = as[z][0];
		end
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		repeat (4) @(posedge cpu_clk);
		`CHK("idle address", 19'h00000, addr)
		for (int i = 0; i < 7; i++) access(i);
		// freeze the access side mclk registers (not the reset synchroniser) and watch the clocks stand
		@(posedge mclk);
		clk_en <= 1'b0;
		repeat (2) @(posedge mclk);
		frz = {bus_clock_out, ptc};
		repeat (6) @(posedge mclk);
		`CHK("frozen clocks", frz, {bus_clock_out, ptc})
		close_out();
	end
endmodule : tb_ext_bus_access_phase_timer
